// ---- design/iom_axil_slave.v ----
/*
 * axi4-lite slave front end: one write and one read at a time, turns
 * bus accesses into a register write strobe and a read address.
 * assumes a single clock and a combinational read data source.
 */
`timescale 1ns/1ns
`include "iom_consts.vh"
module iom_axil_slave (
    // clock and reset
    input  wire        core_clk,
    input  wire        srst,
    // write channels
    input  wire [7:0]  awaddr,
    input  wire        awvalid,
    output reg         awready,
    input  wire [31:0] wdata,
    input  wire [3:0]  wstrb,
    input  wire        wvalid,
    output reg         wready,
    output reg  [1:0]  bresp,
    output reg         bvalid,
    input  wire        bready,
    // read channels
    input  wire [7:0]  araddr,
    input  wire        arvalid,
    output reg         arready,
    output reg  [31:0] rdata,
    output reg  [1:0]  rresp,
    output reg         rvalid,
    input  wire        rready,
    // register side
    output reg         regWr,
    output reg  [7:0]  regWrAddr,
    output reg  [31:0] regWrData,
    output wire [7:0]  regRdAddr,
    input  wire [31:0] regRdData,
    input  wire        regRdOk,
    input  wire        regWrOk
);
reg        awHave_q;
reg        wHave_q;
reg [7:0]  awAddr_q;
reg [31:0] wData_q;
reg [7:0]  arAddr_q;
reg        rPend_q;
//----------------------------------------------------------------
// write path: catch address and data in either order
//----------------------------------------------------------------
always @(posedge core_clk) begin
    if (srst) begin
        awready   <= 1'b0;
        wready    <= 1'b0;
        awHave_q  <= 1'b0;
        wHave_q   <= 1'b0;
        awAddr_q  <= 8'h00;
        wData_q   <= 32'h00000000;
        bvalid    <= 1'b0;
        bresp     <= `IOM_RESP_OKAY;
        regWr     <= 1'b0;
        regWrAddr <= 8'h00;
        regWrData <= 32'h00000000;
    end else begin
        regWr   <= 1'b0;
        awready <= !awHave_q && !bvalid && !awready && awvalid;
        wready  <= !wHave_q && !bvalid && !wready && wvalid;
        if (awvalid && awready) begin
            awHave_q <= 1'b1;
            awAddr_q <= awaddr;
        end
        if (wvalid && wready) begin
            wHave_q <= 1'b1;
            // partial strobes still write the whole word
            wData_q <= wdata;
        end
        if (awHave_q && wHave_q && !bvalid && !regWr) begin
            regWr     <= 1'b1;
            regWrAddr <= awAddr_q;
            regWrData <= wData_q;
        end
        if (regWr) begin
            bvalid   <= 1'b1;
            bresp    <= regWrOk ? `IOM_RESP_OKAY : `IOM_RESP_SLVERR;
            awHave_q <= 1'b0;
            wHave_q  <= 1'b0;
        end else if (bvalid && bready) begin
            bvalid <= 1'b0;
        end
    end
end
//----------------------------------------------------------------
// read path: address then one data beat
//----------------------------------------------------------------
assign regRdAddr = arAddr_q;
always @(posedge core_clk) begin
    if (srst) begin
        arready  <= 1'b0;
        arAddr_q <= 8'h00;
        rPend_q  <= 1'b0;
        rvalid   <= 1'b0;
        rdata    <= 32'h00000000;
        rresp    <= `IOM_RESP_OKAY;
    end else begin
        arready <= !rPend_q && !rvalid && !arready && arvalid;
        if (arvalid && arready) begin
            arAddr_q <= araddr;
            rPend_q  <= 1'b1;
        end
        if (rPend_q) begin
            rPend_q <= 1'b0;
            rvalid  <= 1'b1;
            rdata   <= regRdOk ? regRdData : 32'h00000000;
            rresp   <= regRdOk ? `IOM_RESP_OKAY : `IOM_RESP_SLVERR;
        end else if (rvalid && rready) begin
            rvalid <= 1'b0;
        end
    end
end
endmodule

// ---- design/iom_bank.v ----
/*
 * one bank of io lines: select registers feed a per-line mux between
 * software, function A and function B, registered toward the pad.
 * assumes synchronous pad inputs and a bus front end that writes it.
 */
`timescale 1ns/1ns
`include "iom_consts.vh"
module iom_bank #(
    parameter [31:0] PER_RST  = 32'h00000000,
    parameter [31:0] SELB_RST = 32'h00000000,
    parameter [31:0] PULL_RST = 32'hFFFFFFFF,
    parameter [31:0] PULL_MSK = 32'hFFFFFFFF
) (
    // clock and reset
    input  wire        core_clk,
    input  wire        srst,
    // register writes
    input  wire        wrEn,
    input  wire [3:0]  wrReg,
    input  wire [31:0] wrData,
    // register state
    output wire [31:0] perEn,
    output wire [31:0] selB,
    output wire [31:0] swOe,
    output wire [31:0] swOut,
    output wire [31:0] pullEn,
    // peripheral side
    input  wire [31:0] funcAOut,
    input  wire [31:0] funcAOe,
    input  wire [31:0] funcBOut,
    input  wire [31:0] funcBOe,
    output wire [31:0] funcAIn,
    output wire [31:0] funcBIn,
    // pad side
    input  wire [31:0] padIn,
    output wire [31:0] padOut,
    output wire [31:0] padOe,
    output wire [31:0] padPull
);
reg [31:0] perEn_q;
reg [31:0] selB_q;
reg [31:0] swOe_q;
reg [31:0] swOut_q;
reg [31:0] pull_q;
reg [31:0] padOut_q;
reg [31:0] padOe_q;
//----------------------------------------------------------------
// select and software registers
//----------------------------------------------------------------
// power-up defaults per bank come in as parameters
always @(posedge core_clk) begin
    if (srst) begin
        perEn_q <= PER_RST;
        selB_q  <= SELB_RST;
        swOe_q  <= 32'h00000000;
        swOut_q <= 32'h00000000;
        pull_q  <= PULL_RST;
    end else if (wrEn) begin
        case (wrReg)
            `IOM_OFF_PER:  perEn_q <= wrData;
            `IOM_OFF_SELB: selB_q  <= wrData;
            `IOM_OFF_OEN:  swOe_q  <= wrData;
            `IOM_OFF_OUT:  swOut_q <= wrData;
            `IOM_OFF_PULL: pull_q  <= wrData & PULL_MSK;
            default: ;
        endcase
    end
end
//----------------------------------------------------------------
// per-line mux, registered so each line changes cleanly
//----------------------------------------------------------------
genvar i;
generate
    for (i = 0; i < `IOM_LINES; i = i + 1) begin : gLine
        // every line updates independently; no bank-wide glitch
        always @(posedge core_clk) begin
            if (srst) begin
                padOut_q[i] <= 1'b0;
                padOe_q[i]  <= 1'b0;
            end else if (!perEn_q[i]) begin
                padOut_q[i] <= swOut_q[i];
                padOe_q[i]  <= swOe_q[i];
            end else if (selB_q[i]) begin
                padOut_q[i] <= funcBOut[i];
                padOe_q[i]  <= funcBOe[i];
            end else begin
                padOut_q[i] <= funcAOut[i];
                padOe_q[i]  <= funcAOe[i];
            end
        end
        // deselected peripheral inputs sit at 0
        assign funcAIn[i] = perEn_q[i] & ~selB_q[i] & padIn[i];
        assign funcBIn[i] = perEn_q[i] &  selB_q[i] & padIn[i];
    end
endgenerate
assign perEn   = perEn_q;
assign selB    = selB_q;
assign swOe    = swOe_q;
assign swOut   = swOut_q;
assign pullEn  = pull_q;
assign padOut  = padOut_q;
assign padOe   = padOe_q;
assign padPull = pull_q;
endmodule

// ---- design/iom_consts.vh ----
/*
 * constants for the io line function mux: bank width, power-up function
 * selects and pull-up defaults, and register offsets.
 * assumes inclusion by bare name from the design modules.
 */
`ifndef IOM_CONSTS_VH
`define IOM_CONSTS_VH
//----------------------------------------------------------------
// bank geometry
//----------------------------------------------------------------
`define IOM_LINES        32
//----------------------------------------------------------------
// power-up selects: periph enable (1=peripheral) and A/B (1=B)
//----------------------------------------------------------------
`define IOM_A_PER_RST    32'hFCE00000
`define IOM_A_SELB_RST   32'h00600000
`define IOM_B_PER_RST    32'hF0000000
`define IOM_B_SELB_RST   32'h00000000
`define IOM_C_PER_RST    32'h00000000
`define IOM_C_SELB_RST   32'h00000000
`define IOM_A_PULL_RST   32'hFEFFFFFF
`define IOM_A_PULL_MASK  32'hFEFFFFFF
`define IOM_ALL_RST      32'hFFFFFFFF
`define IOM_BOOT_LINE    24
//----------------------------------------------------------------
// register map per bank, bank stride 0x40
//----------------------------------------------------------------
`define IOM_OFF_PER      4'h0
`define IOM_OFF_SELB     4'h1
`define IOM_OFF_OEN      4'h2
`define IOM_OFF_OUT      4'h3
`define IOM_OFF_PULL     4'h4
`define IOM_OFF_PIN      4'h5
`define IOM_OFF_BOOT     4'h6
`define IOM_RESP_OKAY    2'h0
`define IOM_RESP_SLVERR  2'h2
`endif

// ---- design/iom_top.v ----
/*
 * io line function mux: three banks of 32 lines, each line under
 * software or one of two peripheral functions, with register access
 * over axi4-lite and a few named peripheral taps.
 * assumes all inputs synchronous to core_clk, srst synchronous high.
 */
// The address map and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/1ns
`include "iom_consts.vh"
module iom_top (
    // clock and reset
    input  wire        core_clk,
    input  wire        srst,
    // axi4-lite write
    input  wire [7:0]  awaddr,
    input  wire        awvalid,
    output wire        awready,
    input  wire [31:0] wdata,
    input  wire [3:0]  wstrb,
    input  wire        wvalid,
    output wire        wready,
    output wire [1:0]  bresp,
    output wire        bvalid,
    input  wire        bready,
    // axi4-lite read
    input  wire [7:0]  araddr,
    input  wire        arvalid,
    output wire        arready,
    output wire [31:0] rdata,
    output wire [1:0]  rresp,
    output wire        rvalid,
    input  wire        rready,
    // peripheral function outputs and enables, bank A/B/C
    input  wire [95:0] funcAOut,
    input  wire [95:0] funcAOe,
    input  wire [95:0] funcBOut,
    input  wire [95:0] funcBOe,
    // peripheral function inputs
    output reg  [95:0] funcAIn,
    output reg  [95:0] funcBIn,
    // named taps
    input  wire        serialRtsOut,
    input  wire        dspModeOut,
    input  wire        cpuClockMonitor,
    input  wire        dspClockMonitor,
    input  wire        ethTransmitEnable,
    output reg         timerIn0,
    output reg         timerIn1,
    output reg         externalInterrupt1,
    output reg         dspInterrupt1,
    output reg         bootMemorySelect,
    // pads
    input  wire [95:0] padIn,
    output wire [95:0] padOut,
    output wire [95:0] padOe,
    output wire [95:0] padPull
);
wire        regWr;
wire [7:0]  regWrAddr;
wire [31:0] regWrData;
wire [7:0]  regRdAddr;
reg  [31:0] regRdData;
reg         regRdOk;
reg         regWrOk;
wire [95:0] perEn;
wire [95:0] selB;
wire [95:0] swOe;
wire [95:0] swOut;
wire [95:0] pullEn;
wire [95:0] bankAIn;
wire [95:0] bankBIn;
reg  [95:0] aOut;
reg  [95:0] bOut;
reg  [95:0] aOe;
reg  [95:0] bOe;
reg         srstDly_q;
reg         boot_q;
//----------------------------------------------------------------
// bus slave
//----------------------------------------------------------------
iom_axil_slave uSlave (
    .core_clk  (core_clk),
    .srst      (srst),
    .awaddr    (awaddr),
    .awvalid   (awvalid),
    .awready   (awready),
    .wdata     (wdata),
    .wstrb     (wstrb),
    .wvalid    (wvalid),
    .wready    (wready),
    .bresp     (bresp),
    .bvalid    (bvalid),
    .bready    (bready),
    .araddr    (araddr),
    .arvalid   (arvalid),
    .arready   (arready),
    .rdata     (rdata),
    .rresp     (rresp),
    .rvalid    (rvalid),
    .rready    (rready),
    .regWr     (regWr),
    .regWrAddr (regWrAddr),
    .regWrData (regWrData),
    .regRdAddr (regRdAddr),
    .regRdData (regRdData),
    .regRdOk   (regRdOk),
    .regWrOk   (regWrOk)
);
//----------------------------------------------------------------
// write decode: address [7:6] bank, [5:2] register
//----------------------------------------------------------------
always @* begin
    regWrOk = (regWrAddr[7:6] != 2'h3) && (regWrAddr[5:2] <= `IOM_OFF_PULL);
end
//----------------------------------------------------------------
// function wiring, with named taps overlaid on the generic buses
//----------------------------------------------------------------
always @* begin
    aOut = funcAOut;
    bOut = funcBOut;
    aOe  = funcAOe;
    bOe  = funcBOe;
    aOut[10] = serialRtsOut;
    aOe[10]  = 1'b1;
    bOe[10]  = 1'b0;
    bOut[21] = dspClockMonitor;
    bOe[21]  = 1'b1;
    bOut[22] = cpuClockMonitor;
    bOe[22]  = 1'b1;
    aOut[23] = ethTransmitEnable;
    aOe[23]  = 1'b1;
    aOe[24]  = 1'b0;
    aOe[12]  = 1'b0;
    aOe[56]  = 1'b0;
    bOut[56] = dspModeOut;
    bOe[56]  = 1'b1;
end
//----------------------------------------------------------------
// banks, one generate loop with per-bank power-up values
//----------------------------------------------------------------
genvar b;
generate
    for (b = 0; b < 3; b = b + 1) begin : gBank
        iom_bank #(
            .PER_RST  (b == 0 ? `IOM_A_PER_RST :
                       b == 1 ? `IOM_B_PER_RST : `IOM_C_PER_RST),
            .SELB_RST (b == 0 ? `IOM_A_SELB_RST :
                       b == 1 ? `IOM_B_SELB_RST : `IOM_C_SELB_RST),
            .PULL_RST (b == 0 ? `IOM_A_PULL_RST : `IOM_ALL_RST),
            .PULL_MSK (b == 0 ? `IOM_A_PULL_MASK : `IOM_ALL_RST)
        ) uBank (
            .core_clk (core_clk),
            .srst     (srst),
            .wrEn     (regWr && regWrOk && regWrAddr[7:6] == b),
            .wrReg    (regWrAddr[5:2]),
            .wrData   (regWrData),
            .perEn    (perEn[b*32 +: 32]),
            .selB     (selB[b*32 +: 32]),
            .swOe     (swOe[b*32 +: 32]),
            .swOut    (swOut[b*32 +: 32]),
            .pullEn   (pullEn[b*32 +: 32]),
            .funcAOut (aOut[b*32 +: 32]),
            .funcAOe  (aOe[b*32 +: 32]),
            .funcBOut (bOut[b*32 +: 32]),
            .funcBOe  (bOe[b*32 +: 32]),
            .funcAIn  (bankAIn[b*32 +: 32]),
            .funcBIn  (bankBIn[b*32 +: 32]),
            .padIn    (padIn[b*32 +: 32]),
            .padOut   (padOut[b*32 +: 32]),
            .padOe    (padOe[b*32 +: 32]),
            .padPull  (padPull[b*32 +: 32])
        );
    end
endgenerate
//----------------------------------------------------------------
// peripheral inputs, registered so top outputs come from flops
//----------------------------------------------------------------
always @(posedge core_clk) begin
    if (srst) begin
        funcAIn            <= {96{1'b0}};
        funcBIn            <= {96{1'b0}};
        timerIn0           <= 1'b0;
        timerIn1           <= 1'b0;
        externalInterrupt1 <= 1'b0;
        dspInterrupt1      <= 1'b0;
    end else begin
        funcAIn            <= bankAIn;
        funcBIn            <= bankBIn;
        timerIn1           <= bankBIn[10];
        externalInterrupt1 <= bankAIn[12];
        dspInterrupt1      <= bankAIn[12];
        timerIn0           <= bankAIn[56];
    end
end
//----------------------------------------------------------------
// boot memory select: caught at the first edge after reset release
//----------------------------------------------------------------
// sampling only on release keeps later pin wiggles from reaching boot
always @(posedge core_clk) begin
    srstDly_q <= srst;
    if (srst) begin
        boot_q <= 1'b0;
    end else if (srstDly_q) begin
        boot_q <= padIn[`IOM_BOOT_LINE];
    end
end
always @* begin
    bootMemorySelect = boot_q;
end
//----------------------------------------------------------------
// read mux
//----------------------------------------------------------------
always @* begin
    regRdOk   = regRdAddr[7:6] != 2'h3;
    regRdData = 32'h00000000;
    case (regRdAddr[5:2])
        `IOM_OFF_PER:  regRdData = perEn[regRdAddr[7:6]*32 +: 32];
        `IOM_OFF_SELB: regRdData = selB[regRdAddr[7:6]*32 +: 32];
        `IOM_OFF_OEN:  regRdData = swOe[regRdAddr[7:6]*32 +: 32];
        `IOM_OFF_OUT:  regRdData = swOut[regRdAddr[7:6]*32 +: 32];
        `IOM_OFF_PULL: regRdData = pullEn[regRdAddr[7:6]*32 +: 32];
        `IOM_OFF_PIN:  regRdData = padIn[regRdAddr[7:6]*32 +: 32];
        `IOM_OFF_BOOT: regRdData = {31'h00000000, boot_q};
        default:       regRdOk   = 1'b0;
    endcase
end
endmodule

// ---- verification/io_line_function_mux_tb_top.sv ----
/*
 * bench for the io line mux: bus tasks, shadow state, scenarios.
 * assumes iom_top, pad model and checker compiled alongside.
 */
`timescale 1ns/1ns
`include "iom_consts.vh"
module io_line_function_mux_tb_top;
    //----------
    // signals
    //----------
    reg         core_clk = 1'b0;
    reg         srst     = 1'b1;
    reg  [7:0]  awaddr   = 8'h00;
    reg  [7:0]  araddr   = 8'h00;
    reg  [31:0] wdata    = 32'h0;
    reg         awvalid  = 1'b0;
    reg         wvalid   = 1'b0;
    reg         arvalid  = 1'b0;
    reg  [95:0] fAOut    = {3{32'hC3A55A3C}};
    reg  [95:0] fBOut    = {3{32'h96E1691E}};
    reg  [95:0] fAOe     = {32'h0, 32'hFEFFFFFF, 32'hFFFFEBFF};
    reg  [95:0] fBOe     = {32'hFFFF0000, 32'h0000FFFF, 32'hFFFFFBFF};
    reg  [95:0] extEn    = {32'h0, 64'hFFFFFFFFFFFFFFFF};
    reg  [95:0] extVal   = {3{32'h0F0FA0A0}};
    reg         rts      = 1'b0;
    reg         mode     = 1'b0;
    reg         cpuCk    = 1'b0;
    reg         dspCk    = 1'b1;
    reg         etx      = 1'b0;
    reg         bootLvl  = 1'b1;
    reg  [95:0] perS, selS, oeS, outS, pullS;
    wire        awready, wready, bvalid, arready, rvalid;
    wire [1:0]  bresp, rresp;
    wire [31:0] rdata;
    wire [95:0] funcAIn, funcBIn, padIn, padOut, padOe, padPull;
    wire        timerIn0, timerIn1, extIrq1, dspIrq1, bootSel;
    integer     err_total  = 0;
    integer     n_compared = 0;
    localparam [1:0] OK  = `IOM_RESP_OKAY;
    localparam [1:0] ERR = `IOM_RESP_SLVERR;
    // taps replace bus bits, enables forced on
    wire [95:0] aO = {fAOut[95:24], etx, fAOut[22:11], rts, fAOut[9:0]};
    wire [95:0] bO = {fBOut[95:57], mode, fBOut[55:23], cpuCk, dspCk,
                      fBOut[20:0]};
    wire [95:0] aE = fAOe | 96'h800400;
    wire [95:0] bE = fBOe | 96'h0100000000600000;
    initial forever #5 core_clk = ~core_clk;
    iom_top DUT (
        .core_clk(core_clk), .srst(srst), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hF),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(1'b1), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(1'b1), .funcAOut(fAOut), .funcAOe(fAOe),
        .funcBOut(fBOut), .funcBOe(fBOe), .funcAIn(funcAIn),
        .funcBIn(funcBIn), .serialRtsOut(rts), .dspModeOut(mode),
        .cpuClockMonitor(cpuCk), .dspClockMonitor(dspCk),
        .ethTransmitEnable(etx), .timerIn0(timerIn0), .timerIn1(timerIn1),
        .externalInterrupt1(extIrq1), .dspInterrupt1(dspIrq1),
        .bootMemorySelect(bootSel), .padIn(padIn), .padOut(padOut),
        .padOe(padOe), .padPull(padPull));
    iom_pad_model PADS (
        .core_clk(core_clk), .padOut(padOut), .padOe(padOe),
        .padPull(padPull), .bootLvl(bootLvl), .extEn(extEn),
        .extVal(extVal), .padIn(padIn));
    //----------
    // shared tasks
    //----------
    function [95:0] expMux(input [95:0] a, input [95:0] b, input [95:0] s);
        begin
            expMux = (perS & ((selS & b) | (~selS & a))) | (~perS & s);
        end
    endfunction
    task check(input string what, input [95:0] seen, input [95:0] exp);
        begin
            n_compared = n_compared + 1;
            if (seen !== exp) begin
                err_total = err_total + 1;
                $display("ERROR %s expected %h seen %h", what, exp, seen);
            end
        end
    endtask
    task test_done;
        begin
            if (err_total == 0 && n_compared > 0)
                $display("DONE - PASS");
            else
                $display("DONE - FAIL");
            $finish;
        end
    endtask
    // reset restores the shadow state
    task do_reset;
        begin
            srst <= 1'b1;
            repeat (16) @(posedge core_clk);
            srst <= 1'b0;
            perS  = {32'h0, 32'hF0000000, 32'hFCE00000};
            selS  = {64'h0, 32'h00600000};
            oeS   = 96'h0;
            outS  = 96'h0;
            pullS = {64'hFFFFFFFFFFFFFFFF, 32'hFEFFFFFF};
            @(posedge core_clk);
        end
    endtask
    task wr(input [1:0] b, input [3:0] r, input [31:0] d, input [1:0] er);
        integer n;
        reg [1:0] resp;
        begin
            awaddr <= {b, r, 2'b00};
            wdata <= d;
            awvalid <= 1'b1;
            wvalid <= 1'b1;
            resp = 2'h3;
            for (n = 0; n < 40 && resp === 2'h3; n = n + 1) begin
                @(posedge core_clk);
                if (awready) awvalid <= 1'b0;
                if (wready) wvalid <= 1'b0;
                if (bvalid) resp = bresp;
            end
            check("bresp", resp, er);
            if (er === OK) begin
                case (r)
                    4'h0: perS[b*32 +: 32] = d;
                    4'h1: selS[b*32 +: 32] = d;
                    4'h2: oeS[b*32 +: 32] = d;
                    4'h3: outS[b*32 +: 32] = d;
                    4'h4: pullS[b*32 +: 32] = d;
                    default: ;
                endcase
                pullS[24] = 1'b0;
            end
        end
    endtask
    task rd(input [1:0] b, input [3:0] r, input [31:0] ed, input [1:0] er);
        integer n;
        reg [1:0] resp;
        reg [31:0] d;
        begin
            araddr <= {b, r, 2'b00};
            arvalid <= 1'b1;
            resp = 2'h3;
            for (n = 0; n < 40 && resp === 2'h3; n = n + 1) begin
                @(posedge core_clk);
                if (arready) arvalid <= 1'b0;
                if (rvalid) {resp, d} = {rresp, rdata};
            end
            check("rresp", resp, er);
            check("rdata", d, ed);
        end
    endtask
    // one edge for the pad flop, one for input capture; ends on an edge
    task cmp_all;
        begin
            repeat (2) @(posedge core_clk);
            #1;
            check("padOut", padOut, expMux(aO, bO, outS));
            check("padOe", padOe, expMux(aE, bE, oeS));
            check("padPull", padPull, pullS);
            check("tmr1", timerIn1, perS[10] & selS[10] & padIn[10]);
            check("tmr0", timerIn0, perS[56] & ~selS[56] & padIn[56]);
            check("irq", {dspIrq1, extIrq1},
                  {2{perS[12] & ~selS[12] & padIn[12]}});
            @(posedge core_clk);
        end
    endtask
    //----------
    // scenarios
    //----------
    task t_power_up;
        begin
            cmp_all;
            check("bootSel", bootSel, 96'h1);
            rd(2'h0, `IOM_OFF_PER, 32'hFCE00000, OK);
            rd(2'h0, `IOM_OFF_SELB, 32'h00600000, OK);
            rd(2'h1, `IOM_OFF_PER, 32'hF0000000, OK);
            rd(2'h2, `IOM_OFF_PER, 32'h0, OK);
            rd(2'h0, `IOM_OFF_PULL, 32'hFEFFFFFF, OK);
            rd(2'h0, `IOM_OFF_BOOT, 32'h1, OK);
        end
    endtask
    task t_regs;
        begin
            wr(2'h3, 4'h0, 32'hFFFFFFFF, ERR);
            wr(2'h0, `IOM_OFF_PIN, 32'h0, ERR);
            rd(2'h0, 4'h7, 32'h0, ERR);
            rd(2'h3, 4'h0, 32'h0, ERR);
            wr(2'h0, `IOM_OFF_PULL, 32'hFFFFFFFF, OK);
            rd(2'h0, `IOM_OFF_PULL, 32'hFEFFFFFF, OK);
            wr(2'h2, `IOM_OFF_PULL, 32'h0000FFFF, OK);
            wr(2'h2, `IOM_OFF_OEN, 32'h00FF00FF, OK);
            wr(2'h2, `IOM_OFF_OUT, 32'h12345678, OK);
            cmp_all;
        end
    endtask
    task t_lines;
        begin
            extVal <= extVal | 96'h0100000000001400;
            wr(2'h0, `IOM_OFF_PER, 32'hFCE01400, OK);
            rts <= 1'b1;
            cmp_all;
            wr(2'h0, `IOM_OFF_SELB, 32'h00600400, OK);
            cmp_all;
            wr(2'h1, `IOM_OFF_PER, 32'hF1000000, OK);
            cmp_all;
            wr(2'h1, `IOM_OFF_SELB, 32'h01000000, OK);
            mode <= 1'b1;
            dspCk <= 1'b0;
            cpuCk <= 1'b1;
            etx <= 1'b1;
            fAOut <= ~fAOut;
            extVal <= extVal ^ 96'h1000;
            cmp_all;
        end
    endtask
    task t_boot;
        begin
            bootLvl <= 1'b0;
            cmp_all;
            check("bootSel", bootSel, 96'h1);
            do_reset;
            cmp_all;
            check("bootSel", bootSel, 96'h0);
            rd(2'h0, `IOM_OFF_BOOT, 32'h0, OK);
        end
    endtask
    //----------
    // main sequence and watchdog
    //----------
    initial begin
        do_reset;
        t_power_up;
        t_regs;
        t_lines;
        t_boot;
        test_done;
    end
    // ten thousand cycles means a hang
    initial begin
        #100000;
        err_total = err_total + 1;
        test_done;
    end
endmodule

// ---- verification/iom_mux_properties.sv ----
/*
 * checker for the io line mux: pads, function inputs, taps, bus.
 * assumes binding to iom_top and the constants header on the path.
 */
`timescale 1ns/1ns
`include "iom_consts.vh"
module iom_mux_properties (
    // clock and reset
    input wire        core_clk,
    input wire        srst,
    // pads and function inputs
    input wire [95:0] padIn,
    input wire [95:0] padOe,
    input wire [95:0] padPull,
    input wire [95:0] funcAIn,
    input wire [95:0] funcBIn,
    // named taps
    input wire        timerIn0,
    input wire        timerIn1,
    input wire        externalInterrupt1,
    input wire        dspInterrupt1,
    input wire        bootMemorySelect,
    // bus handshakes
    input wire        awvalid,
    input wire        awready,
    input wire        bvalid,
    input wire        arvalid,
    input wire        arready,
    input wire        rvalid,
    input wire [1:0]  rresp,
    input wire [31:0] rdata
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (srst);
    //----------
    // pads and strap
    //----------
    // never disabled: it checks the reset values
    reset_state_a: assert property (disable iff (1'b0)
        srst |=> padOe == 96'h0 &&
        padPull == {64'hFFFFFFFFFFFFFFFF, 32'hFEFFFFFF})
        else $error("pads not in reset state");
    pull_line24_a: assert property (padPull[24] == 1'b0)
        else $error("pull-up on strap line");
    boot_load_a: assert property (!srst && $past(srst) |=>
        bootMemorySelect == $past(padIn[24]))
        else $error("boot select not loaded");
    boot_hold_a: assert property (!$past(srst) && !$past(srst, 2) |->
        $stable(bootMemorySelect))
        else $error("boot select moved");
    //----------
    // function inputs
    //----------
    one_func_a: assert property ((funcAIn & funcBIn) == 96'h0)
        else $error("both functions fed");
    func_from_pad_a: assert property (
        ((funcAIn | funcBIn) & ~$past(padIn)) == 96'h0)
        else $error("input without pad");
    tap_timer_a: assert property (timerIn1 == funcBIn[10] &&
        timerIn0 == funcAIn[56])
        else $error("timer tap wrong");
    irq_pair_a: assert property (dspInterrupt1 == externalInterrupt1 &&
        externalInterrupt1 == funcAIn[12])
        else $error("interrupt taps disagree");
    //----------
    // bus answers
    //----------
    write_answer_a: assert property (awvalid && awready |-> ##[1:4] bvalid)
        else $error("write response late");
    read_answer_a: assert property (arvalid && arready |-> ##[1:4] rvalid)
        else $error("read response late");
    err_rdata_a: assert property (rvalid && rresp == `IOM_RESP_SLVERR |->
        rdata == 32'h0)
        else $error("error read carries data");
endmodule
bind iom_top iom_mux_properties u_props (.*);

// ---- verification/iom_pad_model.sv ----
/*
 * pad and board model: design drive, board driver, strap, pull-up.
 * assumes pad enables high while the design drives the line.
 */
`timescale 1ns/1ns
module iom_pad_model (
    // clock
    input  wire        core_clk,
    // design side of the pads
    input  wire [95:0] padOut,
    input  wire [95:0] padOe,
    input  wire [95:0] padPull,
    // board side
    input  wire        bootLvl,
    input  wire [95:0] extEn,
    input  wire [95:0] extVal,
    output wire [95:0] padIn
);
    reg  [95:0] floatQ = 96'h0;
    wire [95:0] lvl;
    // undriven lines with no pull-up wander
    always @(posedge core_clk) begin
        floatQ <= ~floatQ;
    end
    // design drive, then board, then pull-up
    assign lvl = (padOe & padOut) | (~padOe & extEn & extVal) |
                 (~padOe & ~extEn & (padPull | floatQ));
    // strap line always has its board resistor
    assign padIn = {lvl[95:25], padOe[24] ? padOut[24] : bootLvl,
                    lvl[23:0]};
endmodule
